// file: core/rsc_flags.sv
// Sticky reset cause flag store
`timescale 1ns/1ps
`include "rsc_defs.svh"
module rsc_flags
	import rsc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	rsc_flag_if.flags fl
);

	rsc_cause_t next_cause;

	// ----------------------------------------
	// Software write, then hardware set on top
	// ----------------------------------------
	always_comb begin
		next_cause = fl.cause;
		if (fl.wr_en) begin
			next_cause = fl.wr_data;
		end
		next_cause = next_cause | fl.hw_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fl.cause <= `RSC_CAUSE_RST;
		end else begin
			fl.cause <= next_cause;
		end
	end

endmodule

// file: core/rsc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rsc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// ----------------------------------------
	// Filter: a change counts when stages two and three agree
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= next_q;
		end
	end

endmodule

// file: core/rsc_top.sv
// Reset source combiner: master reset generation, cause flags and APB registers
`timescale 1ns/1ps
`include "rsc_defs.svh"

module rsc_top
	import rsc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int N_PERIPH = 8,
	parameter int STRETCH_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic brown_out_reset,
	input wire logic external_clear_pin_reset_n,
	input wire logic software_instruction_reset,
	input wire logic watchdog_timeout_reset,
	input wire logic config_mismatch_reset,
	input wire logic trap_conflict_reset,
	input wire logic illegal_opcode_reset,
	input wire logic uninit_wreg_reset,
	input wire logic security_reset,
	output logic master_system_reset,
	output logic cpu_reset,
	output logic [N_PERIPH-1:0] periph_reset
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
		$error("rsc_top: ADDR_W must be 4 to 32");
	end
	if (N_PERIPH < 1 || N_PERIPH > 32) begin : g_bad_periph
		$error("rsc_top: N_PERIPH must be 1 to 32");
	end
	if (STRETCH_W < 1 || STRETCH_W > 32) begin : g_bad_stretch
		$error("rsc_top: STRETCH_W must be 1 to 32");
	end
	if (`RSC_STRETCH_CYC >= (64'h1 << STRETCH_W)) begin : g_bad_cyc
		$error("rsc_top: STRETCH_W too small for default stretch");
	end

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam logic [STRETCH_W-1:0] STRETCH_RST = STRETCH_W'(`RSC_STRETCH_CYC);
	localparam logic [N_PERIPH-1:0] SCOPE_RST = '1;

	rsc_flag_if fl ();

	logic [1:0] pin_raw;
	logic [1:0] pin_sync;
	logic bor_live;
	logic ext_live;
	logic ill_live;
	rsc_cause_t src_live;
	logic any_src;

	rsc_state_t state;
	rsc_state_t next_state;
	logic [STRETCH_W-1:0] cnt;
	logic [STRETCH_W-1:0] next_cnt;
	logic next_master;
	logic [N_PERIPH-1:0] next_periph;

	logic [N_PERIPH-1:0] scope;
	logic [N_PERIPH-1:0] next_scope;
	logic [STRETCH_W-1:0] stretch;
	logic [STRETCH_W-1:0] next_stretch;

	logic access_wait;
	logic access_done;
	logic wr_done;
	logic mapped;
	logic [31:0] rdata;
	logic [31:0] status_word;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic hit_cause;
	logic hit_status;
	logic hit_scope;
	logic hit_stretch;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		addr_hit = (a == ADDR_W'(ofs));
	endfunction

	// ----------------------------------------
	// Register select
	// ----------------------------------------
	always_comb begin
		hit_cause = addr_hit(paddr, `RSC_CAUSE_OFS);
		hit_status = addr_hit(paddr, `RSC_STATUS_OFS);
		hit_scope = addr_hit(paddr, `RSC_SCOPE_OFS);
		hit_stretch = addr_hit(paddr, `RSC_STRETCH_OFS);
		mapped = hit_cause || hit_status || hit_scope || hit_stretch;
	end

	// ----------------------------------------
	// Pin sources through synchroniser
	// ----------------------------------------
	assign pin_raw = {external_clear_pin_reset_n, brown_out_reset};

	rsc_sync #(
		.W(2),
		.RST_VAL(2'b10)
	) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pin_raw),
		.q(pin_sync)
	);

	// ----------------------------------------
	// Source gathering
	// ----------------------------------------
	always_comb begin
		bor_live = pin_sync[0];
		ext_live = ~pin_sync[1];
		ill_live = illegal_opcode_reset | uninit_wreg_reset | security_reset;
		src_live = '0;
		src_live[`RSC_BIT_BOR] = bor_live;
		src_live[`RSC_BIT_EXT] = ext_live;
		src_live[`RSC_BIT_SWI] = software_instruction_reset;
		src_live[`RSC_BIT_WDT] = watchdog_timeout_reset;
		src_live[`RSC_BIT_CFG] = config_mismatch_reset;
		src_live[`RSC_BIT_TRAP] = trap_conflict_reset;
		src_live[`RSC_BIT_ILL] = ill_live;
		any_src = |src_live;
	end

	// ----------------------------------------
	// Cause flag store
	// ----------------------------------------
	assign fl.hw_set = src_live;
	assign fl.wr_en = wr_done && hit_cause;
	assign fl.wr_data = pwdata[7:0];

	rsc_flags u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.fl(fl.flags)
	);

	// ----------------------------------------
	// Master reset sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		unique case (state)
			RS_HOLD: begin
				if (!any_src) begin
					next_state = RS_STRETCH;
					next_cnt = stretch;
				end
			end
			RS_STRETCH: begin
				if (any_src) begin
					next_state = RS_HOLD;
				end else if (cnt == '0) begin
					next_state = RS_RUN;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			RS_RUN: begin
				if (any_src) begin
					next_state = RS_HOLD;
				end
			end
			default: begin
				next_state = RS_HOLD;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= RS_HOLD;
			cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	// ----------------------------------------
	// Reset outputs
	// ----------------------------------------
	always_comb begin
		next_master = (next_state != RS_RUN);
		next_periph = {N_PERIPH{next_master}} & scope;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_system_reset <= 1'b1;
			cpu_reset <= 1'b1;
			periph_reset <= SCOPE_RST;
		end else begin
			master_system_reset <= next_master;
			cpu_reset <= next_master;
			periph_reset <= next_periph;
		end
	end

	// ----------------------------------------
	// Control registers, kept through master reset
	// ----------------------------------------
	always_comb begin
		next_scope = scope;
		next_stretch = stretch;
		if (wr_done && hit_scope) begin
			next_scope = pwdata[N_PERIPH-1:0];
		end
		if (wr_done && hit_stretch) begin
			next_stretch = pwdata[STRETCH_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scope <= SCOPE_RST;
			stretch <= STRETCH_RST;
		end else begin
			scope <= next_scope;
			stretch <= next_stretch;
		end
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_comb begin
		status_word = '0;
		status_word[7:0] = src_live;
		status_word[`RSC_ST_OPC] = illegal_opcode_reset;
		status_word[`RSC_ST_UWR] = uninit_wreg_reset;
		status_word[`RSC_ST_SEC] = security_reset;
		status_word[`RSC_ST_MASTER] = master_system_reset;
		status_word[`RSC_ST_STRETCH] = (state == RS_STRETCH);
	end

	// ----------------------------------------
	// Read data select
	// ----------------------------------------
	always_comb begin
		rdata = '0;
		if (hit_cause) begin
			rdata[7:0] = fl.cause;
		end else if (hit_status) begin
			rdata = status_word;
		end else if (hit_scope) begin
			rdata[N_PERIPH-1:0] = scope;
		end else if (hit_stretch) begin
			rdata[STRETCH_W-1:0] = stretch;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		access_wait = psel && penable && !pready;
		access_done = psel && penable && pready;
		wr_done = access_done && pwrite && !pslverr;
		next_pready = access_wait;
		next_pslverr = access_wait && !mapped;
		next_prdata = (access_wait && !pwrite) ? rdata : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

endmodule

// file: include/rsc_defs.svh
// Register offsets, field positions, reset values and timing counts of the reset combiner
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSC_CAUSE_OFS 8'h00
`define RSC_STATUS_OFS 8'h04
`define RSC_SCOPE_OFS 8'h08
`define RSC_STRETCH_OFS 8'h0c

// ----------------------------------------
// Reset cause bit positions
// ----------------------------------------
`define RSC_BIT_POR 0
`define RSC_BIT_BOR 1
`define RSC_BIT_EXT 2
`define RSC_BIT_SWI 3
`define RSC_BIT_WDT 4
`define RSC_BIT_CFG 5
`define RSC_BIT_TRAP 6
`define RSC_BIT_ILL 7

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define RSC_ST_OPC 8
`define RSC_ST_UWR 9
`define RSC_ST_SEC 10
`define RSC_ST_MASTER 16
`define RSC_ST_STRETCH 17

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RSC_CAUSE_RST 8'h01
`define RSC_CLK_MHZ 100
`define RSC_STRETCH_NS 100
`define RSC_STRETCH_CYC ((`RSC_STRETCH_NS * `RSC_CLK_MHZ + 999) / 1000)

`endif

// file: include/rsc_flag_if.sv
// Interface between the combiner core and the reset cause flag store
`timescale 1ns/1ps
interface rsc_flag_if;
	import rsc_pkg::*;

	logic wr_en;
	rsc_cause_t wr_data;
	rsc_cause_t hw_set;
	rsc_cause_t cause;

	modport ctrl (
		output wr_en,
		output wr_data,
		output hw_set,
		input cause
	);

	modport flags (
		input wr_en,
		input wr_data,
		input hw_set,
		output cause
	);

endinterface

// file: include/rsc_pkg.sv
// Types shared by the reset combiner modules
package rsc_pkg;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef logic [7:0] rsc_cause_t;

	typedef enum logic [1:0] {
		RS_HOLD,
		RS_STRETCH,
		RS_RUN
	} rsc_state_t;

endpackage

// file: testbench/rsc_src_model.sv
// Behavioural model of the reset sources
`timescale 1ns/1ps
module rsc_src_model (
	input wire logic pclk,
	output logic brown_out_reset,
	output logic external_clear_pin_reset_n,
	output logic software_instruction_reset,
	output logic watchdog_timeout_reset,
	output logic config_mismatch_reset,
	output logic trap_conflict_reset,
	output logic illegal_opcode_reset,
	output logic uninit_wreg_reset,
	output logic security_reset
);
	// ----
	// Source lines
	// ----
	logic [8:0] src = '0;
	assign brown_out_reset = src[0];
	assign external_clear_pin_reset_n = !src[1];
	assign software_instruction_reset = src[2];
	assign watchdog_timeout_reset = src[3];
	assign config_mismatch_reset = src[4];
	assign trap_conflict_reset = src[5];
	assign illegal_opcode_reset = src[6];
	assign uninit_wreg_reset = src[7];
	assign security_reset = src[8];
	task pulse(input int i, input int n);
		src[i] <= 1'b1;
		repeat (n) @(posedge pclk);
		src[i] <= 1'b0;
	endtask
endmodule

// file: testbench/rsc_top_props.sv
// Port assertions for the reset combiner
`timescale 1ns/1ps
module rsc_top_props #(
	parameter int N_PERIPH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic brown_out_reset,
	input wire logic external_clear_pin_reset_n,
	input wire logic software_instruction_reset,
	input wire logic watchdog_timeout_reset,
	input wire logic config_mismatch_reset,
	input wire logic trap_conflict_reset,
	input wire logic illegal_opcode_reset,
	input wire logic uninit_wreg_reset,
	input wire logic security_reset,
	input wire logic master_system_reset,
	input wire logic cpu_reset,
	input wire logic [N_PERIPH-1:0] periph_reset
);
	// ----
	// Properties
	// ----
	logic src;
	logic pin_ok;
	assign src = software_instruction_reset | watchdog_timeout_reset | config_mismatch_reset
		| trap_conflict_reset | illegal_opcode_reset | uninit_wreg_reset | security_reset;
	assign pin_ok = !brown_out_reset && external_clear_pin_reset_n;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_src; src |=> master_system_reset; endproperty
	a_src: assert property (p_src) else $error("master late");
	property p_pin; $fell(external_clear_pin_reset_n) ##1 (!external_clear_pin_reset_n)[*5]
		|=> master_system_reset; endproperty
	a_pin: assert property (p_pin) else $error("pin missed");
	property p_ill; (uninit_wreg_reset || security_reset) |=> master_system_reset; endproperty
	a_ill: assert property (p_ill) else $error("illegal missed");
	property p_hold; src |=> master_system_reset[*2]; endproperty
	a_hold: assert property (p_hold) else $error("hold short");
	property p_fall; $fell(master_system_reset) |-> !$past(src); endproperty
	a_fall: assert property (p_fall) else $error("early release");
	property p_cpu; cpu_reset == master_system_reset; endproperty
	a_cpu: assert property (p_cpu) else $error("cpu reset");
	property p_per; periph_reset != '0 |-> master_system_reset; endproperty
	a_per: assert property (p_per) else $error("periph reset");
	property p_rdy; psel && penable && !$past(penable) |-> !pready ##1 pready; endproperty
	a_rdy: assert property (p_rdy) else $error("ready timing");
	property p_sw; pin_ok[*6] ##0 (psel && penable && pready && pwrite && !src
		&& !master_system_reset) |=> !master_system_reset; endproperty
	a_sw: assert property (p_sw) else $error("write reset");
	c_fall: cover property ($fell(master_system_reset));
	c_err: cover property (pslverr);
	c_wr: cover property (psel && penable && pready && pwrite);
endmodule

bind rsc_top rsc_top_props #(.N_PERIPH(N_PERIPH)) u_props (.*);

// file: testbench/tb.sv
// Self-checking bench for the reset combiner
`timescale 1ns/1ps
module tb;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0;
	wire [31:0] prdata;
	wire pready, pslverr, master_system_reset, cpu_reset;
	wire [7:0] periph_reset;
	wire brown_out_reset, external_clear_pin_reset_n, software_instruction_reset;
	wire watchdog_timeout_reset, config_mismatch_reset, trap_conflict_reset;
	wire illegal_opcode_reset, uninit_wreg_reset, security_reset;
	logic [32:0] q[$];
	int checks = 0;
	int bad_count = 0;
	rsc_top dut (.*);
	rsc_src_model m (.*);
	initial forever #5 pclk = ~pclk;
	// ----
	// Tasks
	// ----
	task wrap_up;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task cmp(input string nm, input logic [32:0] e, input logic [32:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		q.push_back(e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			bad_count++;
			wrap_up;
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task hit(input int i, input int n, input int e);
		int c;
		c = 0;
		m.pulse(i, n);
		repeat (40) begin
			@(posedge pclk);
			if (master_system_reset === 1'b1) c++;
		end
		if (e != 0) cmp("hold", e, c);
		else cmp("hit", 1, c != 0);
	endtask
	always @(posedge pclk) if (psel && penable && pready === 1'b1)
		cmp("apb", q.pop_front(), {pslverr, prdata});
	// ----
	// Scenarios
	// ----
	initial begin
		int s, r;
		s = $urandom(32'h0f78);
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		cmp("master", 1, master_system_reset);
		apb(0, 8'h00, '0, 33'h1);
		apb(0, 8'h08, '0, 33'hff);
		apb(0, 8'h0c, '0, 33'ha);
		apb(0, 8'h10, '0, 33'h100000000);
		apb(1, 8'h02, '0, 33'h100000000);
		s = $urandom_range(1, 8);
		apb(1, 8'h0c, s, '0);
		for (int i = 0; i < 9; i++) begin
			apb(1, 8'h00, '0, '0);
			hit(i, i < 2 ? 8 : 1, i < 2 ? 0 : s + 2);
			apb(0, 8'h00, '0, 33'h1 << (i > 6 ? 7 : i + 1));
		end
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			apb(1, 8'h00, r, '0);
			apb(0, 8'h00, '0, r & 32'hff);
			cmp("quiet", 0, master_system_reset);
		end
		r = $urandom_range(0, 255);
		apb(1, 8'h08, r, '0);
		m.pulse(3, 1);
		repeat (2) @(posedge pclk);
		cmp("scope", 32'h100 | r, {cpu_reset, periph_reset});
		repeat (20) @(posedge pclk);
		cmp("scope", 0, {cpu_reset, periph_reset});
		apb(1, 8'h04, 32'hffffffff, '0);
		m.src[7] <= 1'b1;
		apb(0, 8'h04, '0, 33'h10280);
		m.src[7] <= 1'b0;
		apb(1, 8'h00, 32'hfe, '0);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		cmp("master", 1, master_system_reset);
		apb(0, 8'h00, '0, 33'h1);
		cmp("queue", 0, q.size());
		wrap_up;
	end
endmodule
